// ==== tcc_params.svh ====
/*
 * timer counter core: register offsets, field positions, reset values.
 * assumes inclusion by bare name from the package and design modules.
 */
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH

// register byte offsets
`define TCC_OFS_IVEC      16'h012E
`define TCC_OFS_CTRL      16'h0160
`define TCC_OFS_CCTL0     16'h0162
`define TCC_OFS_CCTL1     16'h0164
`define TCC_OFS_CCTL2     16'h0166
`define TCC_OFS_COUNT     16'h0170
`define TCC_OFS_CMP0      16'h0172
`define TCC_OFS_CMP1      16'h0174
`define TCC_OFS_CMP2      16'h0176

// timer control field positions
`define TCC_BIT_FLAG      0
`define TCC_BIT_IE        1
`define TCC_BIT_CLR       2
`define TCC_MC_LO         4
`define TCC_MC_HI         5
`define TCC_ID_LO         6
`define TCC_ID_HI         7
`define TCC_SEL_LO        8
`define TCC_SEL_HI        9

// writable bits of timer control (clear bit never stored)
`define TCC_CTRL_MASK     16'hFFFB
// channel control bits 10, 9 and 3 read only
`define TCC_CCTL_MASK     16'hF9F7

// reset value and count limit
`define TCC_RST_WORD      16'h0000
`define TCC_COUNT_MAX     16'hFFFF
// overflow vector value
`define TCC_IVEC_OVF      16'h000A

`endif

// ==== tcc_pkg.sv ====
/*
 * timer counter core types.
 * assumes tcc_params.svh on the include path.
 */
`include "tcc_params.svh"

package tcc_pkg;

    typedef enum logic [1:0]
    {
        TCC_MODE_STOP,
        TCC_MODE_UP,
        TCC_MODE_CONT,
        TCC_MODE_UPDOWN
    } tcc_mode_t;

    typedef struct packed
    {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } tcc_bus_req_t;

    typedef struct packed
    {
        logic [15:0] value;
        logic        down;
    } tcc_count_t;

endpackage : tcc_pkg

// ==== tcc_clk_div.sv ====
/*
 * clock source select and input divider.
 * assumes source clocks are level inputs synchronous to clk;
 * emits one-cycle tick on each divided rising edge of the chosen source.
 */
`timescale 1ns/1ps

module tcc_clk_div
    import tcc_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // sources
    input  wire logic       external_pin_clock,
    input  wire logic       aux_clock,
    input  wire logic       subsystem_clock,
    // control
    input  wire logic [1:0] clock_source_select,
    input  wire logic [1:0] input_divider,
    input  wire logic       clear,
    // divided tick
    output logic            tick
);

    logic       src_prev;
    logic [2:0] div_cnt;
    wire  logic src_mux;
    wire  logic src_rise;
    wire  logic [2:0] div_last;

    // 11 selects the inverted pin clock
    assign src_mux  = (clock_source_select == 2'h0) ? external_pin_clock :
                      (clock_source_select == 2'h1) ? aux_clock :
                      (clock_source_select == 2'h2) ? subsystem_clock :
                                                      ~external_pin_clock;
    assign src_rise = src_mux & ~src_prev;
    // divide by 1, 2, 4, 8
    assign div_last = 3'((4'h1 << input_divider) - 4'h1);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            src_prev <= 1'b0;
            div_cnt  <= 3'h0;
            tick     <= 1'b0;
        end
        else
        begin
            src_prev <= src_mux;
            tick     <= src_rise && (div_cnt == div_last) && !clear;
            if (clear)
                div_cnt <= 3'h0;
            else if (src_rise)
                div_cnt <= (div_cnt == div_last) ? 3'h0 : 3'(div_cnt + 3'h1);
        end
    end

endmodule : tcc_clk_div

// ==== tcc_counter.sv ====
/*
 * 16-bit counter with stop, up, continuous and up/down modes.
 * assumes tick is a one-cycle enable; software load wins over counting.
 */
`timescale 1ns/1ps
`include "tcc_params.svh"

module tcc_counter
    import tcc_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // control
    input  wire logic        tick,
    input  tcc_mode_t        mode,
    input  wire logic [15:0] period,
    input  wire logic        clear,
    input  wire logic        load,
    input  wire logic [15:0] load_value,
    // state
    output tcc_count_t       count,
    output logic             wrap
);

    tcc_count_t next_count;
    logic       next_wrap;

    always_comb
    begin
        next_count = count;
        next_wrap  = 1'b0;
        if (tick)
        begin
            case (mode)
                TCC_MODE_STOP:
                    next_count = count;
                TCC_MODE_UP:
                begin
                    if (count.value >= period)
                    begin
                        next_count.value = 16'h0000;
                        next_wrap        = 1'b1;
                    end
                    else
                        next_count.value = count.value + 16'h0001;
                end
                TCC_MODE_CONT:
                begin
                    next_count.value = count.value + 16'h0001;
                    next_wrap        = (count.value == `TCC_COUNT_MAX);
                end
                TCC_MODE_UPDOWN:
                begin
                    if (!count.down)
                    begin
                        if (count.value >= period)
                        begin
                            next_count.down  = (period != 16'h0000);
                            next_count.value = (period == 16'h0000) ? 16'h0000
                                             : count.value - 16'h0001;
                        end
                        else
                            next_count.value = count.value + 16'h0001;
                    end
                    else if (count.value == 16'h0001)
                    begin
                        next_count.value = 16'h0000;
                        next_count.down  = 1'b0;
                        next_wrap        = 1'b1;
                    end
                    else
                        next_count.value = count.value - 16'h0001;
                end
                default:
                    next_count = count;
            endcase
        end
        if (load)
            next_count.value = load_value;
        if (clear)
        begin
            next_count = '0;
            next_wrap  = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count <= '0;
            wrap  <= 1'b0;
        end
        else
        begin
            count <= next_count;
            wrap  <= next_wrap;
        end
    end

endmodule : tcc_counter

// ==== tcc_core.sv ====
/*
 * timer counter core: register file, clock selection, counting, overflow
 * request. assumes a plain register port with read data one cycle later.
 */
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "tcc_params.svh"

// Overview of operation
// - mode field 00 halts counter at its present value
// - up mode counts to channel-0 compare then restarts at zero
// - continuous mode counts to FFFFh then rolls over to zero
// - clear bit resets counter, divider, direction; self-clears, reads zero
// - counter register reads and writes the full 16-bit count
// - channel controls at 0162h, 0164h, 0166h, read/write except bits 10, 9, 3 (read zero), reset to zero
module tcc_core
    import tcc_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // register port
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata,
    // timer clock sources
    input  wire logic        external_pin_clock,
    input  wire logic        aux_clock,
    input  wire logic        subsystem_clock,
    // to capture/compare units
    output logic [15:0]      counter_out,
    output logic             count_down,
    output logic             overflow_irq
);

    tcc_bus_req_t req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    ////////////////////////////////////////////////////////////////////////
    // address decode

    wire logic hit_ivec  = (req.addr == `TCC_OFS_IVEC);
    wire logic hit_ctrl  = (req.addr == `TCC_OFS_CTRL);
    wire logic hit_cctl0 = (req.addr == `TCC_OFS_CCTL0);
    wire logic hit_cctl1 = (req.addr == `TCC_OFS_CCTL1);
    wire logic hit_cctl2 = (req.addr == `TCC_OFS_CCTL2);
    wire logic hit_count = (req.addr == `TCC_OFS_COUNT);
    wire logic hit_cmp0  = (req.addr == `TCC_OFS_CMP0);
    wire logic hit_cmp1  = (req.addr == `TCC_OFS_CMP1);
    wire logic hit_cmp2  = (req.addr == `TCC_OFS_CMP2);

    wire logic wr_ctrl  = req.wr && hit_ctrl;
    wire logic wr_count = req.wr && hit_count;
    // vector access clears the pending overflow flag when it is reported
    wire logic ivec_acc = (req.wr || req.rd) && hit_ivec;

    ////////////////////////////////////////////////////////////////////////
    // registers

    // control fields, one flop each; the clear bit has none
    logic [5:0]  ctrl_spare_hi;
    logic [1:0]  clock_source_select;
    logic [1:0]  input_divider;
    logic [1:0]  count_mode_field;
    logic        ctrl_spare_lo;
    logic        overflow_irq_enable;
    logic        overflow_flag;
    logic [15:0] channel0_control;
    logic [15:0] channel1_control;
    logic [15:0] channel2_control;
    logic [15:0] channel0_compare;
    logic [15:0] channel1_compare;
    logic [15:0] channel2_compare;

    // clear bit position always reads zero
    wire logic [15:0] timer_control = {ctrl_spare_hi, clock_source_select, input_divider,
                                       count_mode_field, ctrl_spare_lo, 1'b0,
                                       overflow_irq_enable, overflow_flag};

    wire logic clr_cmd = wr_ctrl && req.wdata[`TCC_BIT_CLR];

    tcc_count_t cnt;
    logic       wrap;
    logic       tick;

    ////////////////////////////////////////////////////////////////////////
    // overflow flag and vector

    wire logic flag_now  = timer_control[`TCC_BIT_FLAG];
    wire logic ie_now    = timer_control[`TCC_BIT_IE];
    wire logic [15:0] interrupt_vector = (flag_now && ie_now) ? `TCC_IVEC_OVF
                                                              : `TCC_RST_WORD;

    // hardware set beats software or vector-access clear
    wire logic flag_sw   = wr_ctrl ? req.wdata[`TCC_BIT_FLAG] : flag_now;
    wire logic flag_acc  = (ivec_acc && flag_now && ie_now) ? 1'b0 : flag_sw;
    wire logic next_flag = wrap | flag_acc;

    wire logic [15:0] ctrl_sw = wr_ctrl ? (req.wdata & `TCC_CTRL_MASK)
                                        : timer_control;
    wire logic [15:0] next_timer_control = {ctrl_sw[15:1], next_flag};

    ////////////////////////////////////////////////////////////////////////
    // control field flops

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            ctrl_spare_hi <= 6'h00;
        else
            ctrl_spare_hi <= next_timer_control[15:(`TCC_SEL_HI + 1)];
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            clock_source_select <= 2'h0;
        else
            clock_source_select <= next_timer_control[`TCC_SEL_HI:`TCC_SEL_LO];
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            input_divider <= 2'h0;
        else
            input_divider <= next_timer_control[`TCC_ID_HI:`TCC_ID_LO];
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            count_mode_field <= 2'h0;
        else
            count_mode_field <= next_timer_control[`TCC_MC_HI:`TCC_MC_LO];
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            ctrl_spare_lo <= 1'b0;
        else
            ctrl_spare_lo <= next_timer_control[`TCC_MC_LO - 1];
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            overflow_irq_enable <= 1'b0;
        else
            overflow_irq_enable <= next_timer_control[`TCC_BIT_IE];
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            overflow_flag <= 1'b0;
        else
            overflow_flag <= next_timer_control[`TCC_BIT_FLAG];
    end

    ////////////////////////////////////////////////////////////////////////
    // channel registers, storage only in this block

    wire logic wr_cctl0 = req.wr && hit_cctl0;
    wire logic wr_cctl1 = req.wr && hit_cctl1;
    wire logic wr_cctl2 = req.wr && hit_cctl2;
    wire logic wr_cmp0  = req.wr && hit_cmp0;
    wire logic wr_cmp1  = req.wr && hit_cmp1;
    wire logic wr_cmp2  = req.wr && hit_cmp2;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            channel0_control <= `TCC_RST_WORD;
        else if (wr_cctl0)
            channel0_control <= req.wdata & `TCC_CCTL_MASK;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            channel1_control <= `TCC_RST_WORD;
        else if (wr_cctl1)
            channel1_control <= req.wdata & `TCC_CCTL_MASK;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            channel2_control <= `TCC_RST_WORD;
        else if (wr_cctl2)
            channel2_control <= req.wdata & `TCC_CCTL_MASK;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            channel0_compare <= `TCC_RST_WORD;
        else if (wr_cmp0)
            channel0_compare <= req.wdata;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            channel1_compare <= `TCC_RST_WORD;
        else if (wr_cmp1)
            channel1_compare <= req.wdata;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            channel2_compare <= `TCC_RST_WORD;
        else if (wr_cmp2)
            channel2_compare <= req.wdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // clock select, divider, counter

    tcc_clk_div u_div
    (
        .clk                 (clk),
        .rst_b               (rst_b),
        .external_pin_clock  (external_pin_clock),
        .aux_clock           (aux_clock),
        .subsystem_clock     (subsystem_clock),
        .clock_source_select (timer_control[`TCC_SEL_HI:`TCC_SEL_LO]),
        .input_divider       (timer_control[`TCC_ID_HI:`TCC_ID_LO]),
        .clear               (clr_cmd),
        .tick                (tick)
    );

    tcc_counter u_cnt
    (
        .clk        (clk),
        .rst_b      (rst_b),
        .tick       (tick),
        .mode       (tcc_mode_t'(timer_control[`TCC_MC_HI:`TCC_MC_LO])),
        .period     (channel0_compare),
        .clear      (clr_cmd),
        .load       (wr_count),
        .load_value (req.wdata),
        .count      (cnt),
        .wrap       (wrap)
    );

    ////////////////////////////////////////////////////////////////////////
    // read back, outputs

    wire logic [15:0] rd_mux =
        hit_ivec  ? interrupt_vector :
        hit_ctrl  ? timer_control    : // clear bit never stored, reads 0
        hit_cctl0 ? channel0_control :
        hit_cctl1 ? channel1_control :
        hit_cctl2 ? channel2_control :
        hit_count ? cnt.value        :
        hit_cmp0  ? channel0_compare :
        hit_cmp1  ? channel1_compare :
        hit_cmp2  ? channel2_compare :
                    `TCC_RST_WORD;

    wire logic [15:0] next_rdata = req.rd ? rd_mux : `TCC_RST_WORD;
    wire logic        next_irq   = next_flag && next_timer_control[`TCC_BIT_IE];

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata <= `TCC_RST_WORD;
        else
            reg_rdata <= next_rdata;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            counter_out <= `TCC_RST_WORD;
        else
            counter_out <= cnt.value;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            count_down <= 1'b0;
        else
            count_down <= cnt.down;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            overflow_irq <= 1'b0;
        else
            overflow_irq <= next_irq;
    end

endmodule : tcc_core

// ==== tcc_core_monitor.sv ====
/*
 * port assertions for tcc_core.
 * assumes one clock domain; bound to every tcc_core instance.
 */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tcc_core_monitor
    import tcc_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    // counter side
    input wire logic [15:0] counter_out,
    input wire logic        count_down,
    input wire logic        overflow_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    wire ctl_rd = reg_rd && reg_addr == 16'h0160;
    wire ctl_wr = reg_wr && reg_addr == 16'h0160;
    wire cctl   = reg_addr inside {16'h0162, 16'h0164, 16'h0166};
    wire mapped = cctl || reg_addr inside {16'h012E, 16'h0160, 16'h0170, 16'h0172,
                                            16'h0174, 16'h0176};
    ////////////////////////////////////////////////////////////////////////////
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("data outside read slot");
    property p_unmapped;
        reg_rd && !mapped |=> reg_rdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_cctl_ro;
        reg_rd && cctl |=> (reg_rdata & 16'h0608) == 16'h0000;
    endproperty
    a_cctl_ro: assert property (p_cctl_ro) else $error("channel ro bits set");
    property p_clr_ro;
        ctl_rd |=> reg_rdata[2] == 1'b0;
    endproperty
    a_clr_ro: assert property (p_clr_ro) else $error("clear bit reads one");
    property p_clear;
        ctl_wr && reg_wdata[2] |=> ##1 counter_out == 16'h0000 && !count_down;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero count");
    property p_cnt_rd;
        reg_rd && reg_addr == 16'h0170 |=> reg_rdata == counter_out;
    endproperty
    a_cnt_rd: assert property (p_cnt_rd) else $error("count read mismatch");
    property p_irq_flag;
        ctl_rd |=> $past(overflow_irq) == (reg_rdata[0] & reg_rdata[1]);
    endproperty
    a_irq_flag: assert property (p_irq_flag) else $error("irq not flag and enable");
    property p_ie_off;
        ctl_wr && !reg_wdata[1] |=> ##1 (!overflow_irq || $past(reg_wr));
    endproperty
    a_ie_off: assert property (p_ie_off) else $error("irq while disabled");
    property p_step;
        $changed(counter_out) && !$past(reg_wr) && !$past(reg_wr, 2) |->
            counter_out == 16'h0000 || counter_out == $past(counter_out) + 16'h0001 ||
            counter_out == $past(counter_out) - 16'h0001;
    endproperty
    a_step: assert property (p_step) else $error("count jumped");
endmodule : tcc_core_monitor

bind tcc_core tcc_core_monitor i_tcc_core_monitor (.clk, .rst_b, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .counter_out, .count_down, .overflow_irq);

// ==== tcc_tb.sv ====
/*
 * self-checking bench for tcc_core.
 * assumes package, core and monitor compiled before it.
 */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tb;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        external_pin_clock = 1'b0;
    logic        aux_clock = 1'b0;
    logic        subsystem_clock = 1'b0;
    logic [15:0] reg_rdata;
    logic [15:0] counter_out;
    logic        count_down;
    logic        overflow_irq;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          per [4] = '{6, 10, 4, 6};
    logic [15:0] adr [10] = '{16'h012E, 16'h0160, 16'h0162, 16'h0164, 16'h0166,
                              16'h0170, 16'h0172, 16'h0174, 16'h0176, 16'h0168};

    tcc_core i_tcc_core (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .external_pin_clock, .aux_clock, .subsystem_clock, .counter_out, .count_down,
        .overflow_irq);

    initial
    begin
        forever #12.5 clk = ~clk;
    end

    // source periods 6, 10, 4 clocks; run ceiling
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc % 3 == 2) external_pin_clock <= ~external_pin_clock;
        if (cyc % 5 == 4) aux_clock <= ~aux_clock;
        if (cyc % 2 == 1) subsystem_clock <= ~subsystem_clock;
        if (cyc == 20000)
        begin
            miscompares++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [15:0] a, input logic [15:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr

    task rd(input logic [15:0] a, input logic [15:0] e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
        @(posedge clk);
    endtask : rd

    task irq(input logic e);
        repeat (2) @(posedge clk);
        chk({15'h0000, overflow_irq}, {15'h0000, e});
    endtask : irq

    // expected successor {direction, count}
    function automatic logic [16:0] nxt(input logic [1:0] m, input logic [15:0] c,
                                        input logic [15:0] v, input logic d);
        if (m == 2'b01) return (v >= c) ? 17'h0_0000 : {1'b0, v + 16'h0001};
        if (m == 2'b10) return {1'b0, v + 16'h0001};
        if (d) return (v == 16'h0001) ? 17'h0_0000 : {1'b1, v - 16'h0001};
        return (v >= c) ? {1'b1, v - 16'h0001} : {1'b0, v + 16'h0001};
    endfunction : nxt

    task follow(input logic [1:0] m, input logic [15:0] c, input int n);
        logic [15:0] v;
        logic        d;
        logic [16:0] e;
        int          t;
        v = counter_out;
        d = 1'b0;
        repeat (n)
        begin
            t = 0;
            while (counter_out === v && t < 400)
            begin
                @(posedge clk);
                t++;
            end
            e = nxt(m, c, v, d);
            chk(counter_out, e[15:0]);
            chk({15'h0000, count_down}, {15'h0000, e[16]});
            {d, v} = e;
        end
    endtask : follow

    // clocks between count steps; first change may be the clear itself
    task gap(input int e);
        logic [15:0] v;
        int          t;
        repeat (3)
        begin
            v = counter_out;
            t = 0;
            while (counter_out === v && t < 100)
            begin
                @(posedge clk);
                t++;
            end
        end
        chk(t[15:0], 16'(e));
    endtask : gap
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [15:0] wd;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 10; i++) rd(adr[i], 16'h0000);
        for (int i = 0; i < 6; i++)
        begin
            wd = 16'hFFFF - 16'(i);
            wr(adr[i < 3 ? i + 2 : i + 3], wd);
            rd(adr[i < 3 ? i + 2 : i + 3], i < 3 ? wd & 16'hF9F7 : wd);
        end
        wr(16'h0160, 16'h0204);
        wr(16'h0170, 16'h1234);
        repeat (40) @(posedge clk);
        rd(16'h0170, 16'h1234);
        rd(16'h0160, 16'h0200);
        wr(16'h0170, 16'hFFFD);
        wr(16'h0160, 16'h0220);
        follow(2'b10, 16'h0000, 5);
        rd(16'h0160, 16'h0221);
        irq(1'b0);
        wr(16'h0160, 16'h0223);
        irq(1'b1);
        rd(16'h012E, 16'h000A);
        irq(1'b0);
        wr(16'h0160, 16'h0203);
        irq(1'b1);
        wr(16'h0160, 16'h0202);
        irq(1'b0);
        wr(16'h0160, 16'h0204);
        wr(16'h0172, 16'h0003);
        wr(16'h0170, 16'h0000);
        wr(16'h0160, 16'h0210);
        follow(2'b01, 16'h0003, 9);
        wr(16'h0160, 16'h0204);
        wr(16'h0160, 16'h0230);
        follow(2'b11, 16'h0003, 12);
        for (int s = 0; s < 4; s++)
        begin
            wr(16'h0160, 16'h0024 | (16'(s) << 8));
            gap(per[s]);
        end
        for (int d = 1; d < 4; d++)
        begin
            wr(16'h0160, 16'h0224 | (16'(d) << 6));
            gap(4 << d);
        end
        wr(16'h0160, 16'h0204);
        rd(16'h0170, 16'h0000);
        print_verdict();
    end
endmodule : tb
